// ==== dv/fixed_point_alu_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module fixed_point_alu_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [14:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic        mem_ack
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [14:0] ra, wa;
  logic [15:0] rv, df;
  logic        seen, fresh;
  // Track last read and write of a copy
  always @(posedge aclk) begin
    if (!aresetn || (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h0)) begin
      seen <= 1'b0;
      fresh <= 1'b0;
    end else if (mem_req && mem_ack) begin
      fresh <= !mem_we;
      seen <= seen || mem_we;
      if (mem_we) wa <= mem_addr;
      if (mem_we) df <= mem_wdata - rv;
      if (!mem_we) ra <= mem_addr;
      if (!mem_we) rv <= mem_rdata;
    end
  end
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable({mem_we, mem_addr, mem_wdata})) else $error("mem request moved");
  a_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("no gap after ack");
  a_read_first: assert property (mem_req && mem_we |-> fresh)
    else $error("write without read");
  a_src_step: assert property (mem_req && !mem_we && seen |-> mem_addr == ra + 15'h1)
    else $error("source not ascending");
  a_dst_step: assert property (mem_req && mem_we && seen |-> mem_addr == wa + 15'h1)
    else $error("destination not ascending");
  a_addend_same: assert property (mem_req && mem_we && seen |-> mem_wdata == rv + df)
    else $error("addend changed");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  a_bad_addr: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr > 8'h23
    |-> ##[1:8] s_axi_bvalid && s_axi_bresp == 2'h2) else $error("no slverr");
endmodule // fixed_point_alu_props
bind fixed_point_alu fixed_point_alu_props u_props (.*);
`default_nettype wire

// ==== dv/fixed_point_alu_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "alu_defines.vh"
module fixed_point_alu_tb;
  typedef struct {string n; logic [31:0] e; logic [31:0] m;} note_t;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, irq_req = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cy;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        mem_req, mem_we, mem_ack;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, seed = 32'h9ef8;
  logic [14:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata, pc = 16'h0, t, k, ac [4];
  logic [16:0] v;
  int          num_errors = 0, num_checks = 0;
  note_t       rq [$];
  logic [1:0]  bq [$], pq [$];
  fixed_point_alu dut (.*);
  mem_model mem (.*);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk(rq.pop_front(), s_axi_rdata);
      chk('{"rresp", {30'h0, pq.pop_front()}, 32'h3}, {30'h0, s_axi_rresp});
    end
    if (s_axi_bvalid && s_axi_bready) chk('{"bresp", {30'h0, bq.pop_front()}, 32'h3},
      {30'h0, s_axi_bresp});
  end
  function automatic logic [15:0] rnd();
    repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  task automatic chk(input note_t x, input logic [31:0] y);
    num_checks++;
    if (((y ^ x.e) & x.m) !== 32'h0) begin
      num_errors++;
      $display("Error %s expected %h seen %h", x.n, x.e & x.m, y & x.m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] w, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, w};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, string n);
    rq.push_back('{n, e, m});
    pq.push_back(a > 8'h23 ? 2'h2 : 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
      if (s_axi_rvalid) d = s_axi_rdata;
    end while (s_axi_arvalid || s_axi_rready);
  endtask
  task automatic ck_all();
    for (int i = 0; i < 4; i++) rd(8'h10 + 8'(4 * i), {16'h0, ac[i]}, '1, "accumulator");
    rd(8'h0c, {29'h0, cy, 2'h0}, 32'h4, "carry");
    rd(8'h20, {16'h0, pc}, '1, "pc");
  endtask
  task automatic load();
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), ac[i], 2'h0);
    wr(8'h0c, {13'h0, cy, 2'h0}, 2'h0);
  endtask
  task automatic run(input logic [15:0] insn, input logic [15:0] imm);
    wr(8'h04, insn, 2'h0);
    wr(8'h08, imm, 2'h0);
    wr(8'h00, 16'h1, 2'h0);
    pc = pc + 16'h1;
    repeat (300) begin
      rd(8'h0c, 32'h0, 32'h0, "busy");
      if (d[0] === 1'b0) break;
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    ac = '{default: 16'h0};
    cy = 1'b0;
    ck_all();
    wr(8'h24, 16'h1, 2'h2);
    rd(8'h40, 32'h0, '1, "unmapped");
    for (int i = 0; i < 12; i++) begin
      logic [2:0] f;
      logic [1:0] c, s;
      f = i % 3 == 0 ? `FN_ADC : i % 3 == 1 ? `FN_ADD : `FN_AND;
      c = 2'(i);
      s = 2'(i / 3);
      ac[0] = rnd();
      ac[1] = i == 11 ? ~ac[0] : rnd();
      cy = seed[20];
      load();
      k = f == `FN_ADC ? ~ac[1] : ac[1];
      v = f == `FN_AND ? {1'b0, ac[0] & k} : {1'b0, ac[0]} + {1'b0, k};
      v[16] = v[16] ^ (c == 2'h0 ? cy : c == 2'h1 ? 1'b0 : c == 2'h2 ? 1'b1 : ~cy);
      v = s == 2'h1 ? {v[15:0], v[16]} : s == 2'h2 ? {v[0], v[16:1]} :
        s == 2'h3 ? {v[16], v[7:0], v[15:8]} : v;
      run({1'b1, 2'h1, 2'h0, f, s, c, i == 10, 3'h4}, 16'h0);
      pc = pc + {15'h0, v[15:0] == 16'h0};
      if (i != 10) {cy, ac[0]} = v;
      ck_all();
    end
    ac[2] = rnd();
    ac[3] = rnd();
    load();
    run({1'b1, 2'h2, 2'h3, `LOW_ANC}, 16'h0);
    ac[3] = ~ac[2] & ac[3];
    ck_all();
    for (int n = 0; n < 4; n++) begin
      ac[n] = n == 3 ? 16'hfffd : rnd();
      load();
      run({1'b1, 2'(n), 2'(n), `LOW_ADI}, 16'h0);
      ac[n] = ac[n] + 16'(n + 1);
      ck_all();
    end
    for (int n = 0; n < 4; n++) begin
      t = rnd();
      run({n[0] ? `TOP_WIDE_IMMEDIATE_SUM_OP : `TOP_IMMEDIATE_MASK_OP, 2'(n), `LOW_WIDE}, t);
      ac[n] = n[0] ? ac[n] + t : ac[n] & t;
      pc = pc + 16'h1;
      ck_all();
    end
    ac = '{rnd(), 16'h3, 16'h7ffe, 16'h8200};
    mem.ram[15'h0200] = 16'h1000;
    for (int i = 0; i < 3; i++) mem.ram[15'h7ffe + 15'(i)] = rnd();
    load();
    run(`OP_BAM, 16'h0);
    for (int i = 0; i < 3; i++) chk('{"copy", {16'h0, mem.ram[15'h7ffe + 15'(i)] + ac[0]}, 32'hffff},
      {16'h0, mem.ram[15'h1000 + 15'(i)]});
    ac = '{ac[0], 16'h0, 16'h1, 16'h1003};
    ck_all();
    for (int i = 0; i < 2; i++) begin
      ac[1] = i == 1 ? 16'h8001 : 16'h0;
      load();
      run(`OP_BAM, 16'h0);
      ck_all();
    end
    // Interrupt pending: indirection resolves, then the copy stops before any word
    ac = '{ac[0], 16'h2, 16'h8200, 16'h0300};
    irq_req <= 1'b1;
    load();
    run(`OP_BAM, 16'h0);
    irq_req <= 1'b0;
    pc = pc - 16'h1;
    ac[2] = 16'h1000;
    ck_all();
    rd(8'h0c, 32'h8, 32'h8, "interrupted");
    end_of_test();
  end
endmodule // fixed_point_alu_tb
`default_nettype wire

// ==== dv/mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  input  wire logic        aclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [14:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output var  logic [15:0] mem_rdata,
  output var  logic        mem_ack
);
  logic [15:0] ram [0:32767];
  logic [15:0] lf = 16'h9ef8;
  logic [1:0]  wt = 2'h0;
  initial begin
    mem_rdata = 16'h0;
    mem_ack = 1'b0;
  end
  // Data toggles outside ack; wait of 0 to 3 cycles
  always @(posedge aclk) begin
    lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wt != 2'h0) wt <= wt - 2'h1;
      else begin
        mem_ack <= 1'b1;
        wt <= lf[1:0];
        if (mem_we) ram[mem_addr] <= mem_wdata;
        else mem_rdata <= ram[mem_addr];
      end
    end
  end
endmodule // mem_model
`default_nettype wire

// ==== logic/alu_defines.vh ====
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH

// ***************************************************
// Register word indices (byte address bits 5:2)
// ***************************************************
`define OFS_CTRL      4'h0
`define OFS_INSN      4'h1
`define OFS_IMM       4'h2
`define OFS_STATUS    4'h3
`define OFS_AC0       4'h4
`define OFS_AC3       4'h7
`define OFS_PC        4'h8
`define CTRL_START    0
`define ST_BUSY       0
`define ST_SKIP       1
`define ST_CARRY      2
`define ST_INTR       3
`define ST_ILLEGAL    4

// ***************************************************
// Instruction fields, bit 15 of the word is the msb
// ***************************************************
`define F_CLASS       15
`define F_ACS         14:13
`define F_ACD         12:11
`define F_FUNC        10:8
`define F_SHIFT       7:6
`define F_CARRY       5:4
`define F_NOLOAD      3
`define F_SKIP        2:0
`define F_LOW11       10:0
`define F_TOP3        15:13

// ***************************************************
// Encodings
// ***************************************************
`define FN_ADC        3'h4
`define FN_ADD        3'h6
`define FN_AND        3'h7
`define LOW_ANC       11'h188
`define LOW_ADI       11'h008
`define LOW_WIDE      11'h7f8
`define TOP_WIDE_IMMEDIATE_SUM_OP      3'h7
`define TOP_IMMEDIATE_MASK_OP      3'h6
`define OP_BAM        16'h97c8
`define CNT_MAX       16'h8000
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ==== logic/fixed_point_alu.v ====
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "alu_defines.vh"

module fixed_point_alu (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        irq_req,
  output reg         mem_req,
  output reg         mem_we,
  output reg  [14:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  input  wire        mem_ack
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_EXEC = 3'h1;
  localparam [2:0] S_IND  = 3'h2;
  localparam [2:0] S_RD   = 3'h3;
  localparam [2:0] S_WR   = 3'h4;
  reg [15:0] ac [0:3];
  reg [15:0] insn, imm, pc;
  reg [2:0]  state;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        carry, skip_flag, intr_flag, illegal, ind_dst, aw_have, w_have;

  // ***************************************************
  // Write channel capture, either order
  // ***************************************************
  wire       wr_go   = aw_have && w_have && !s_axi_bvalid;
  wire [3:0] wr_idx  = aw_addr[5:2];
  wire       wr_map  = (aw_addr[7:6] == 2'h0) && (wr_idx <= `OFS_PC);
  wire [15:0] wmask  = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_have && !s_axi_awready) begin
        aw_have       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !w_have && !s_axi_wready) begin
        w_have       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***************************************************
  // Read channel
  // ***************************************************
  wire [3:0] rd_idx = s_axi_araddr[5:2];
  reg [31:0] rd_val;
  reg        rd_map;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_map = (s_axi_araddr[7:6] == 2'h0);
    case (rd_idx)
      `OFS_CTRL:   rd_val = 32'h0000_0000;
      `OFS_INSN:   rd_val = {16'h0000, insn};
      `OFS_IMM:    rd_val = {16'h0000, imm};
      `OFS_STATUS: rd_val = {27'h0, illegal, intr_flag, carry, skip_flag, state != S_IDLE};
      `OFS_PC:     rd_val = {16'h0000, pc};
      default: begin
        if (rd_idx >= `OFS_AC0 && rd_idx <= `OFS_AC3)
          rd_val = {16'h0000, ac[rd_idx[1:0]]};
        else
          rd_map = 1'b0;
      end
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_map ? rd_val : 32'h0000_0000;
        s_axi_rresp   <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***************************************************
  // Shifter datapath
  // ***************************************************
  wire [15:0] src = ac[insn[`F_ACS]];
  wire [15:0] dst = ac[insn[`F_ACD]];
  reg         c_pre, skp;
  reg  [16:0] sum, v17, sh17;

  always @* begin
    case (insn[`F_CARRY])
      2'h1:    c_pre = 1'b0;
      2'h2:    c_pre = 1'b1;
      2'h3:    c_pre = ~carry;
      default: c_pre = carry;
    endcase
    case (insn[`F_FUNC])
      `FN_ADC: sum = {1'b0, ~src} + {1'b0, dst};
      `FN_ADD: sum = {1'b0, src} + {1'b0, dst};
      default: sum = {1'b0, src & dst};
    endcase
    v17 = {c_pre ^ sum[16], sum[15:0]};
    case (insn[`F_SHIFT])
      2'h1:    sh17 = {v17[15:0], v17[16]};
      2'h2:    sh17 = {v17[0], v17[16:1]};
      2'h3:    sh17 = {v17[16], v17[7:0], v17[15:8]};
      default: sh17 = v17;
    endcase
    case (insn[`F_SKIP])
      3'h1:    skp = 1'b1;
      3'h2:    skp = ~sh17[16];
      3'h3:    skp = sh17[16];
      3'h4:    skp = (sh17[15:0] == 16'h0000);
      3'h5:    skp = (sh17[15:0] != 16'h0000);
      3'h6:    skp = ~sh17[16] || (sh17[15:0] == 16'h0000);
      3'h7:    skp = sh17[16] && (sh17[15:0] != 16'h0000);
      default: skp = 1'b0;
    endcase
  end

  wire        is_ext   = insn[`F_NOLOAD] && (insn[`F_SKIP] == 3'h0); // Taken by other ops
  wire        is_shift = insn[`F_CLASS] && !is_ext && (insn[`F_FUNC] == `FN_ADC ||
                         insn[`F_FUNC] == `FN_ADD || insn[`F_FUNC] == `FN_AND);
  wire        is_anc   = insn[`F_CLASS] && insn[`F_LOW11] == `LOW_ANC;
  wire        is_adi   = insn[`F_CLASS] && insn[`F_LOW11] == `LOW_ADI;
  wire        is_wide_immediate_sum_op  = insn[`F_TOP3] == `TOP_WIDE_IMMEDIATE_SUM_OP && insn[`F_LOW11] == `LOW_WIDE;
  wire        is_immediate_mask_op  = insn[`F_TOP3] == `TOP_IMMEDIATE_MASK_OP && insn[`F_LOW11] == `LOW_WIDE;
  wire        is_bam   = insn == `OP_BAM;
  wire [1:0]  wide_ac  = insn[12:11];
  wire        cnt_ok   = ac[1] != 16'h0000 && ac[1] <= `CNT_MAX;
  wire [14:0] src_next = ac[2][14:0] + 15'h0001;
  wire [14:0] dst_next = ac[3][14:0] + 15'h0001;

  // ***************************************************
  // Control and register file
  // ***************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      ac[0]     <= 16'h0000;
      ac[1]     <= 16'h0000;
      ac[2]     <= 16'h0000;
      ac[3]     <= 16'h0000;
      carry     <= 1'b0;
      insn      <= 16'h0000;
      imm       <= 16'h0000;
      pc        <= 16'h0000;
      state     <= S_IDLE;
      skip_flag <= 1'b0;
      intr_flag <= 1'b0;
      illegal   <= 1'b0;
      ind_dst   <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 15'h0000;
      mem_wdata <= 16'h0000;
    end else if (ce) begin
      if (wr_go && wr_map && state == S_IDLE) begin
        case (wr_idx)
          `OFS_CTRL: begin
            if (w_strb[0] && w_data[`CTRL_START]) begin
              state     <= S_EXEC;
              pc        <= pc + 16'h0001;
              skip_flag <= 1'b0;
              intr_flag <= 1'b0;
              illegal   <= 1'b0;
            end
          end
          `OFS_INSN: insn <= (insn & ~wmask) | (w_data[15:0] & wmask);
          `OFS_IMM:  imm  <= (imm & ~wmask) | (w_data[15:0] & wmask);
          `OFS_PC:   pc   <= (pc & ~wmask) | (w_data[15:0] & wmask);
          `OFS_STATUS: begin
            if (w_strb[0])
              carry <= w_data[`ST_CARRY];
          end
          default:
            ac[wr_idx[1:0]] <= (ac[wr_idx[1:0]] & ~wmask) | (w_data[15:0] & wmask);
        endcase
      end
      case (state)
        S_IDLE: begin end // Start comes from the bus write above
        S_EXEC: begin
          state <= S_IDLE;
          if (is_shift) begin
            if (!insn[`F_NOLOAD]) begin
              carry             <= sh17[16];
              ac[insn[`F_ACD]]  <= sh17[15:0];
            end
            skip_flag <= skp;
            if (skp)
              pc <= pc + 16'h0001;
          end else if (is_anc) begin
            ac[insn[`F_ACD]] <= ~src & dst;
          end else if (is_adi) begin
            ac[insn[`F_ACD]] <= dst + {14'h0000, insn[`F_ACS]} + 16'h0001;
          end else if (is_wide_immediate_sum_op) begin
            ac[wide_ac] <= ac[wide_ac] + imm;
            pc          <= pc + 16'h0001;
          end else if (is_immediate_mask_op) begin
            ac[wide_ac] <= ac[wide_ac] & imm;
            pc          <= pc + 16'h0001;
          end else if (is_bam) begin
            if (cnt_ok) begin
              ind_dst <= ac[2][15] ? 1'b0 : 1'b1;
              state   <= (ac[2][15] || ac[3][15]) ? S_IND : S_RD;
            end
          end else begin
            illegal <= 1'b1;
          end
        end
        S_IND: begin
          // Follow one link per read until bit 15 clears
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= ind_dst ? ac[3][14:0] : ac[2][14:0];
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            if (ind_dst)
              ac[3] <= mem_rdata;
            else
              ac[2] <= mem_rdata;
            if (!mem_rdata[15]) begin
              if (ind_dst || !ac[3][15])
                state <= S_RD;
              else
                ind_dst <= 1'b1;
            end
          end
        end
        S_RD: begin
          if (ac[1] == 16'h0000) begin
            state <= S_IDLE;
          end else if (!mem_req && irq_req) begin
            intr_flag <= 1'b1;
            pc        <= pc - 16'h0001;
            state     <= S_IDLE;
          end else if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= ac[2][14:0];
          end else if (mem_ack) begin
            mem_req   <= 1'b0;
            mem_wdata <= mem_rdata + ac[0];
            state     <= S_WR;
          end
        end
        S_WR: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b1;
            mem_addr <= ac[3][14:0];
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            ac[1]   <= ac[1] - 16'h0001;
            ac[2]   <= {1'b0, src_next};
            ac[3]   <= {1'b0, dst_next};
            state   <= S_RD;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // fixed_point_alu

`default_nettype wire
